// File: pmwp_cfg_if.sv
// Interface: live configuration fields passed between design modules
`timescale 1ns/1ps
`default_nettype none
interface pmwp_cfg_if;
   // Live configuration values
   logic global_code_protect;
   logic global_write_protect;
   logic segment_protect_disable;
   logic segment_boundary_select;
   logic config_page_protect;
   logic [6:0] segment_page_select;
   // Configuration is valid and consistent
   logic cfg_valid;

   modport src (
      output global_code_protect, global_write_protect,
      output segment_protect_disable, segment_boundary_select,
      output config_page_protect, segment_page_select, cfg_valid
   );
   modport dst (
      input global_code_protect, global_write_protect,
      input segment_protect_disable, segment_boundary_select,
      input config_page_protect, segment_page_select, cfg_valid
   );
endinterface
`default_nettype wire

// File: pmwp_cfg_shadow.sv
// Configuration holder with complemented shadow and parity check
`timescale 1ns/1ps
`default_nettype none
module pmwp_cfg_shadow (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Load from flash configuration words
   input wire logic load_strobe,
   input wire logic [11:0] load_data,
   // Cell disturbance injection on the live copy
   input wire logic [11:0] upset_mask,
   // Parity error level, held while live and shadow disagree
   output logic parity_err,
   // Live fields out
   pmwp_cfg_if.src cfg
);
   // ==========================================
   // Storage
   // ==========================================
   // Live copy and its complemented shadow
   logic [11:0] live_reg;
   logic [11:0] shadow_reg;
   // Goes high after first load
   logic loaded_reg;
   // Live vs shadow mismatch
   logic mismatch;

   // Load both copies together; disturbance flips live bits only
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         live_reg <= pmwp_pkg::CFG_RESET;
         shadow_reg <= ~pmwp_pkg::CFG_RESET;
         loaded_reg <= 1'b0;
      end else if (clk_en) begin
         if (load_strobe) begin
            live_reg <= load_data;
            shadow_reg <= ~load_data;
            loaded_reg <= 1'b1;
         end else begin
            live_reg <= live_reg ^ upset_mask;
         end
      end
   end

   assign mismatch = (live_reg ^ shadow_reg) != 12'hF_FF;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         parity_err <= 1'b0;
      end else if (clk_en) begin
         parity_err <= mismatch;
      end
   end

   // Field extraction
   assign cfg.global_code_protect = live_reg[pmwp_pkg::CFG_GCP_BIT];
   assign cfg.global_write_protect = live_reg[pmwp_pkg::CFG_GLOBAL_WRITE_PROTECT_BIT];
   assign cfg.segment_protect_disable = live_reg[pmwp_pkg::CFG_DIS_BIT];
   assign cfg.segment_boundary_select = live_reg[pmwp_pkg::CFG_END_BIT];
   assign cfg.config_page_protect = live_reg[pmwp_pkg::CFG_CPG_BIT];
   assign cfg.segment_page_select =
      live_reg[pmwp_pkg::CFG_PAGE_LSB +: pmwp_pkg::PAGE_SEL_W];
   assign cfg.cfg_valid = loaded_reg & ~mismatch;
endmodule // pmwp_cfg_shadow
`default_nettype wire

// File: pmwp_nvm_model.sv
// Partner: memory controller and external programmer asking for checks
`timescale 1ns/1ps
`default_nettype none
module pmwp_nvm_model (
   // Clock
   input wire logic clock,
   // Requests
   output logic nvm_req,
   output logic [23:0] nvm_addr,
   output logic ext_req,
   // Answers
   input wire logic nvm_grant,
   input wire logic nvm_deny,
   input wire logic ext_grant,
   input wire logic ext_deny
);
   // Idle at time zero
   initial begin
      nvm_req = 1'b0;
      ext_req = 1'b0;
      nvm_addr = 24'h00_0000;
   end
   // One request cycle, then a bounded wait for its answer
   task automatic check(input logic ext, input logic [23:0] a,
      output logic g, output logic d);
      int n;
      g = 1'b0;
      d = 1'b0;
      @(posedge clock);
      nvm_req <= !ext;
      ext_req <= ext;
      nvm_addr <= a;
      @(posedge clock);
      nvm_req <= 1'b0;
      ext_req <= 1'b0;
      // Released address shows its inverse, never a stale value
      nvm_addr <= ~a;
      for (n = 0; n < 8 && !(g || d); n++) begin
         @(posedge clock);
         g = ext ? ext_grant : nvm_grant;
         d = ext ? ext_deny : nvm_deny;
      end
   endtask
endmodule // pmwp_nvm_model
`default_nettype wire

// File: pmwp_pkg.sv
// Package: constants and types for program memory write protection
package pmwp_pkg;
   // ==========================================
   // Memory geometry
   // ==========================================
   // Word address width of program memory
   localparam int ADDR_W = 24;
   // Page size in words
   localparam int PAGE_WORDS = 512;
   // Bits of word address inside one page
   localparam int PAGE_SHIFT = 9;
   // Width of the page selector
   localparam int PAGE_SEL_W = 7;
   // Default last implemented word address (parameter default)
   localparam logic [23:0] LAST_ADDR_DEF = 24'h01_57FF;
   // Bottom of program memory
   localparam logic [23:0] MEM_BOTTOM = 24'h00_0000;

   // ==========================================
   // Configuration word layout (live copy)
   // ==========================================
   localparam int CFG_W = 12;
   localparam int CFG_GCP_BIT = 0;
   localparam int CFG_GLOBAL_WRITE_PROTECT_BIT = 1;
   localparam int CFG_DIS_BIT = 2;
   localparam int CFG_END_BIT = 3;
   localparam int CFG_CPG_BIT = 4;
   localparam int CFG_PAGE_LSB = 5;
   // Reset value: everything unprogrammed (all ones, nothing protected
   // except as loaded later)
   localparam logic [11:0] CFG_RESET = 12'h0_FFF;

   // ==========================================
   // Interrupt status bits
   // ==========================================
   localparam int EV_W = 3;
   localparam int EV_DENY_BIT = 0;
   localparam int EV_EXT_BIT = 1;
   localparam int EV_PAR_BIT = 2;

   // Outcome of an internal request check
   typedef enum logic [1:0] {
      PMWP_OK = 2'b00,
      PMWP_DENY_GLOBAL = 2'b01,
      PMWP_DENY_SEGMENT = 2'b10,
      PMWP_DENY_CFGPAGE = 2'b11
   } pmwp_verdict_t;
endpackage

// File: pmwp_range_check.sv
// Address range decision for segment and configuration page
`timescale 1ns/1ps
`default_nettype none
module pmwp_range_check #(
   parameter logic [23:0] LAST_ADDR = pmwp_pkg::LAST_ADDR_DEF
) (
   // Target word address
   input wire logic [23:0] addr,
   // Configuration
   pmwp_cfg_if.dst cfg,
   // Hits
   output logic seg_hit,
   output logic cfg_page_hit
);
   // Page boundaries of the selected page
   logic [23:0] page_first;
   logic [23:0] page_last;
   logic [23:0] last_page_first;

   assign page_first = {8'h00, cfg.segment_page_select,
                        {pmwp_pkg::PAGE_SHIFT{1'b0}}};
   assign page_last = {8'h00, cfg.segment_page_select,
                       {pmwp_pkg::PAGE_SHIFT{1'b1}}};
   // First word of the last implemented page
   assign last_page_first = {LAST_ADDR[23:pmwp_pkg::PAGE_SHIFT],
                             {pmwp_pkg::PAGE_SHIFT{1'b0}}};

   // Segment range decision
   always_comb begin
      seg_hit = 1'b0;
      cfg_page_hit = 1'b0;
      if (!cfg.segment_protect_disable) begin
         if (cfg.segment_boundary_select) begin
            seg_hit = addr >= page_first;
         end else begin
            seg_hit = (addr >= pmwp_pkg::MEM_BOTTOM) && (addr <= page_last);
         end
         if (!cfg.config_page_protect) begin
            cfg_page_hit = addr >= last_page_first;
         end
      end
   end
endmodule // pmwp_range_check
`default_nettype wire

// File: pmwp_sva.sv
// Checker: protection decisions seen at the top ports
`timescale 1ns/1ps
`default_nettype none
module pmwp_sva #(
   parameter logic [23:0] LAST_ADDR = pmwp_pkg::LAST_ADDR_DEF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Configuration source
   input wire logic cfg_load,
   input wire logic [11:0] cfg_word,
   input wire logic [11:0] cfg_upset,
   // Checks and answers
   input wire logic nvm_req,
   input wire logic [23:0] nvm_addr,
   input wire logic nvm_grant,
   input wire logic nvm_deny,
   input wire logic ext_req,
   input wire logic ext_grant,
   input wire logic ext_deny,
   input wire logic dev_reset
);
   // ==========================================
   // Reference copy of the loaded configuration
   // ==========================================
   logic [11:0] cfg_reg;
   logic vld_reg;
   logic upset_reg;
   logic ok, seg, cpg;
   logic [23:0] base;
   // Copy taken on each load
   always_ff @(posedge clock) begin
      if (clk_en && cfg_load) cfg_reg <= cfg_word;
   end
   // Valid after a load; an upset makes the copy stale until reload
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         vld_reg <= 1'b0;
         upset_reg <= 1'b0;
      end else if (clk_en && cfg_load) begin
         vld_reg <= 1'b1;
         upset_reg <= 1'b0;
      end else if (clk_en && cfg_upset != 12'h000) begin
         upset_reg <= 1'b1;
      end
   end
   assign base = {8'h00, cfg_reg[11:5], 9'h000};
   // Only judged when the copy surely matches the live value
   assign ok = vld_reg && !upset_reg && clk_en && !cfg_load
      && cfg_upset == 12'h000;
   assign seg = !cfg_reg[2] && (cfg_reg[3] ? nvm_addr >= base
      : nvm_addr <= (base | 24'h00_01FF));
   assign cpg = !cfg_reg[2] && !cfg_reg[4]
      && nvm_addr >= {LAST_ADDR[23:9], 9'h000};

   // ==========================================
   // Assertions
   // ==========================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_one_answer: assert property (
      nvm_req && clk_en |=> nvm_grant != nvm_deny)
      else $error("check answer not exactly one");
   a_idle_quiet: assert property (
      !nvm_req && clk_en |=> !nvm_grant && !nvm_deny)
      else $error("answer without request");
   a_wp_block: assert property (
      nvm_req && ok && !cfg_reg[1] |=> nvm_deny)
      else $error("write lock not applied");
   a_seg_block: assert property (
      nvm_req && ok && seg |=> nvm_deny)
      else $error("segment range not protected");
   a_global_kept: assert property (
      nvm_req && ok && !cfg_reg[1] && !seg |=> !nvm_grant)
      else $error("global lock lifted outside segment");
   a_cfgpage_block: assert property (
      nvm_req && ok && cpg |=> nvm_deny)
      else $error("config page not protected");
   a_free_grant: assert property (
      nvm_req && ok && cfg_reg[1] && !seg && !cpg |=> nvm_grant)
      else $error("free address refused");
   a_code_lock: assert property (
      ext_req && ok && !cfg_reg[0] |=> ext_deny && !ext_grant)
      else $error("external access not refused");
   a_unloaded_deny: assert property (
      nvm_req && !vld_reg && !cfg_load |=> !nvm_grant)
      else $error("grant before configuration load");
   a_parity_reset: assert property (
      cfg_upset != 12'h000 && clk_en && vld_reg |-> ##[1:3] dev_reset)
      else $error("upset without device reset");
   // Main scenarios reached
   c_deny: cover property (nvm_req ##1 nvm_deny);
   c_grant: cover property (nvm_req ##1 nvm_grant);
   c_parity: cover property ($rose(dev_reset));
endmodule // pmwp_sva
bind pmwp_top pmwp_sva #(.LAST_ADDR(LAST_ADDR)) pmwp_sva_i (
   .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
   .cfg_load(cfg_load), .cfg_word(cfg_word), .cfg_upset(cfg_upset),
   .nvm_req(nvm_req), .nvm_addr(nvm_addr), .nvm_grant(nvm_grant),
   .nvm_deny(nvm_deny), .ext_req(ext_req), .ext_grant(ext_grant),
   .ext_deny(ext_deny), .dev_reset(dev_reset)
);
`default_nettype wire

// File: pmwp_top.sv
// Program memory write protection: top level with AHB-Lite registers
// Notes on behaviour
// - Code protect refuses external reads and writes
// - Write protect zero blocks internal write/erase
// - Writes inside segment range lose interlock
// - Segment only adds, never lifts global
// - Segment enabled only when disable is zero
// - Seven-bit page select, page included
// - Boundary zero: bottom through selected page
// - Boundary one: selected page through end
// - Config-page bit zero protects last page
// - Disable one: only global locks apply
// - Complemented shadow compared continuously
// - Disturbed configuration bit forces device reset
// - Configuration loaded from flash words
`timescale 1ns/1ps
`default_nettype none
module pmwp_top #(
   parameter logic [23:0] LAST_ADDR = pmwp_pkg::LAST_ADDR_DEF
) (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Configuration source (flash configuration words)
   input wire logic cfg_load,
   input wire logic [11:0] cfg_word,
   input wire logic [11:0] cfg_upset,
   // Internal write/erase request from memory controller
   input wire logic nvm_req,
   input wire logic [23:0] nvm_addr,
   output logic nvm_grant,
   output logic nvm_deny,
   // External programmer access request
   input wire logic ext_req,
   output logic ext_grant,
   output logic ext_deny,
   // Device reset and interrupt
   output logic dev_reset,
   output logic irq
);
   // ==========================================
   // Register map
   // ==========================================
   // Byte offsets; only haddr[7:0] is
   // decoded, so the map repeats above it
   // Status and mask share one layout:
   // bit 0 internal deny, bit 1 external
   // refusal, bit 2 configuration upset
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_LAST = 8'h0C;

   // ==========================================
   // Configuration holder and range checker
   // ==========================================
   // The holder owns the live copy and its
   // complement; the checker only reads
   // fields, so it stays combinational and
   // answers for the address it is given
   pmwp_cfg_if cfg_bus ();
   // Parity error level from holder, held until reload
   logic parity_err;
   // Range hits
   logic seg_hit;
   logic cfg_page_hit;

   pmwp_cfg_shadow u_shadow (
      .clock(clock),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .load_strobe(cfg_load),
      .load_data(cfg_word),
      .upset_mask(cfg_upset),
      .parity_err(parity_err),
      .cfg(cfg_bus.src)
   );

   // The range checker sees only the
   // internal request address; external
   // access is judged on the global code
   // protect setting and on cfg_ok
   pmwp_range_check #(.LAST_ADDR(LAST_ADDR)) u_range (
      .addr(nvm_addr),
      .cfg(cfg_bus.dst),
      .seg_hit(seg_hit),
      .cfg_page_hit(cfg_page_hit)
   );

   // ==========================================
   // Decisions
   // ==========================================
   // Verdict for the current internal request
   pmwp_pkg::pmwp_verdict_t verdict;
   // External access blocked
   logic ext_block;
   // Configuration loaded and consistent;
   // until then every request is refused so
   // a blank or upset setting never opens
   // memory that should stay locked
   logic cfg_ok;

   assign cfg_ok = cfg_bus.cfg_valid;

   // Order only picks the verdict code: any
   // deny reason refuses the request, and
   // the global lock is reported first
   // Global lock checked first so segment can never lift it
   always_comb begin
      if (!cfg_bus.global_write_protect || !cfg_ok) begin
         verdict = pmwp_pkg::PMWP_DENY_GLOBAL;
      end else if (seg_hit) begin
         verdict = pmwp_pkg::PMWP_DENY_SEGMENT;
      end else if (cfg_page_hit) begin
         verdict = pmwp_pkg::PMWP_DENY_CFGPAGE;
      end else begin
         verdict = pmwp_pkg::PMWP_OK;
      end
   end

   // External access ignores the segment
   // settings: segment protection only
   // guards internal write and erase
   // code protect active when programmed to zero
   assign ext_block = ~cfg_bus.global_code_protect | ~cfg_ok;

   // ==========================================
   // Grant outputs
   // ==========================================
   // Answers are registered so every top
   // output comes from a flip-flop; the
   // cost is one cycle of latency, which
   // the memory controller must wait out
   // A request held for several cycles
   // gets one answer per cycle
   // Internal request answer, one cycle after request
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         nvm_grant <= 1'b0;
         nvm_deny <= 1'b0;
      end else if (clk_en) begin
         nvm_grant <= nvm_req && (verdict == pmwp_pkg::PMWP_OK);
         nvm_deny <= nvm_req && (verdict != pmwp_pkg::PMWP_OK);
      end
   end

   // External access answer; normal execution is not routed here
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ext_grant <= 1'b0;
         ext_deny <= 1'b0;
      end else if (clk_en) begin
         ext_grant <= ext_req && !ext_block;
         ext_deny <= ext_req && ext_block;
      end
   end

   // The reset stays high while the live
   // copy disagrees with its shadow; only a
   // fresh load or a system reset ends it,
   // as no trusted value is left to use
   // Device reset on configuration disturbance
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dev_reset <= 1'b0;
      end else if (clk_en) begin
         dev_reset <= parity_err;
      end
   end

   // ==========================================
   // Interrupt status and mask
   // ==========================================
   // Sticky events: deny, external refuse, parity
   logic [2:0] status_reg;
   logic [2:0] status_next;
   logic [2:0] mask_reg;
   logic [2:0] events;
   // Write-one-to-clear bits from the bus
   logic [2:0] w1c;

   assign events[pmwp_pkg::EV_DENY_BIT] = nvm_deny;
   assign events[pmwp_pkg::EV_EXT_BIT] = ext_deny;
   assign events[pmwp_pkg::EV_PAR_BIT] = dev_reset;

   // A deny pulse sets its bit once, while
   // a held device reset keeps setting bit
   // 2, so clearing that bit only sticks
   // after the configuration is reloaded
   // Set wins over clear in the same cycle
   assign status_next = (status_reg & ~w1c) | events;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status_reg <= 3'h0;
      end else if (clk_en) begin
         status_reg <= status_next;
      end
   end

   // Level interrupt from next status value and mask, registered
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(status_next & mask_reg);
      end
   end

   // ==========================================
   // AHB-Lite slave
   // ==========================================
   // Captured address phase
   logic dp_valid_reg;
   logic dp_write_reg;
   logic [7:0] dp_addr_reg;
   // Address phase accepted this cycle
   logic ap_take;

   assign ap_take = hsel && hready && htrans[1];

   // Zero wait state slave: the address
   // phase is captured on the edge that
   // accepts it, and a write lands on the
   // edge that ends its data phase
   // hsize is not checked; only whole word
   // transfers are expected on this port
   // The capture only moves while hready
   // is high, so a stalled bus keeps the
   // last accepted address phase
   // Capture address phase
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else if (clk_en) begin
         if (hready) begin
            dp_valid_reg <= ap_take;
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr[7:0];
         end
      end
   end

   // Write strobes in data phase
   logic wr_act;
   assign wr_act = dp_valid_reg && dp_write_reg;
   assign w1c = (wr_act && dp_addr_reg == OFS_STATUS) ? hwdata[2:0] : 3'h0;

   // Mask bits only gate the interrupt;
   // status keeps recording events even
   // while their mask bit is clear
   // Mask register write
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mask_reg <= 3'h0;
      end else if (clk_en) begin
         if (wr_act && dp_addr_reg == OFS_MASK) begin
            mask_reg <= hwdata[2:0];
         end
      end
   end

   // The mux looks at the live address
   // phase so the data can be registered
   // Read data mux, registered so it stands in the data phase
   logic [31:0] rd_next;
   always_comb begin
      case (haddr[7:0])
         OFS_STATUS: rd_next = {29'h0, status_reg};
         OFS_MASK: rd_next = {29'h0, mask_reg};
         OFS_CFG: rd_next = {19'h0, cfg_bus.cfg_valid,
                             cfg_bus.segment_page_select,
                             cfg_bus.config_page_protect,
                             cfg_bus.segment_boundary_select,
                             cfg_bus.segment_protect_disable,
                             cfg_bus.global_write_protect,
                             cfg_bus.global_code_protect};
         OFS_LAST: rd_next = {8'h00, LAST_ADDR};
         // Unmapped reads as zero
         default: rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (ap_take && !hwrite) begin
            hrdata <= rd_next;
         end
      end
   end

   // Kept outside the clock enable so the
   // bus never stalls while state is frozen
   // Zero wait states, OKAY always
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule // pmwp_top
`default_nettype wire

// File: test_program_memory_write_protection.sv
// Testbench: protection decisions, registers, interrupt and parity reset
`timescale 1ns/1ps
`default_nettype none
module test_program_memory_write_protection;
   // ==========================================
   // Stimulus and observed signals
   // ==========================================
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, g, d;
   logic cfg_load = 1'b0;
   logic [11:0] cfg_word = 12'hFFF, cfg_upset = 12'h000;
   logic nvm_req, ext_req, nvm_grant, nvm_deny, ext_grant, ext_deny;
   logic [23:0] nvm_addr;
   logic dev_reset, irq;
   int fail_count = 0, check_count = 0, cycle_count = 0;

   always #4 clock = ~clock;

   pmwp_top pmwp_top_i (.clock(clock), .sys_rst(sys_rst),
      .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cfg_load(cfg_load), .cfg_word(cfg_word),
      .cfg_upset(cfg_upset), .nvm_req(nvm_req), .nvm_addr(nvm_addr),
      .nvm_grant(nvm_grant), .nvm_deny(nvm_deny), .ext_req(ext_req),
      .ext_grant(ext_grant), .ext_deny(ext_deny),
      .dev_reset(dev_reset), .irq(irq));
   pmwp_nvm_model pmwp_nvm_model_i (.clock(clock), .nvm_req(nvm_req),
      .nvm_addr(nvm_addr), .ext_req(ext_req), .nvm_grant(nvm_grant),
      .nvm_deny(nvm_deny), .ext_grant(ext_grant), .ext_deny(ext_deny));

   // ==========================================
   // Compare, bus and run tasks
   // ==========================================
   task automatic check_bit(input string n, input logic e, input logic s);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic check_word(input string n, input logic [31:0] e,
      input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [31:0] a,
      input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic rd_chk(input string n, input logic [31:0] a,
      input logic [31:0] e);
      ahb(1'b0, a, 32'h0000_0000);
      check_word(n, e, rd);
   endtask
   task automatic load(input logic [11:0] w);
      @(posedge clock);
      cfg_load <= 1'b1;
      cfg_word <= w;
      @(posedge clock);
      cfg_load <= 1'b0;
   endtask
   // Load a setting, then one internal and one external check
   task automatic run_case(input logic [11:0] w, input logic [23:0] a,
      input logic dn, input logic dx);
      load(w);
      pmwp_nvm_model_i.check(1'b0, a, g, d);
      check_bit("nvm_deny", dn, d);
      check_bit("nvm_grant", !dn, g);
      pmwp_nvm_model_i.check(1'b1, a, g, d);
      check_bit("ext_deny", dx, d);
      check_bit("ext_grant", !dx, g);
   endtask

   // Hang guard
   always @(posedge clock) begin
      cycle_count++;
      if (cycle_count == 5000) begin
         fail_count++;
         complete_run;
      end
   end

   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      pmwp_nvm_model_i.check(1'b0, 24'h00_0100, g, d);
      check_bit("unloaded", 1'b1, d);
      rd_chk("cfg reset", 32'h08, 32'h0000_0FFF);
      run_case(12'hFFF, 24'h00_0100, 1'b0, 1'b0);
      run_case(12'hFFD, 24'h00_0100, 1'b1, 1'b0);
      run_case(12'hFFE, 24'h00_0100, 1'b0, 1'b1);
      run_case(12'h053, 24'h00_05FF, 1'b1, 1'b0);
      run_case(12'h053, 24'h00_0600, 1'b0, 1'b0);
      run_case(12'h05B, 24'h00_0400, 1'b1, 1'b0);
      run_case(12'h05B, 24'h00_03FF, 1'b0, 1'b0);
      run_case(12'h043, 24'h01_5600, 1'b1, 1'b0);
      run_case(12'h043, 24'h01_55FF, 1'b0, 1'b0);
      run_case(12'h047, 24'h01_5600, 1'b0, 1'b0);
      run_case(12'h051, 24'h00_1000, 1'b1, 1'b0);
      // Read-only places keep their value
      ahb(1'b1, 32'h08, 32'hFFFF_FFFF);
      rd_chk("cfg live", 32'h08, 32'h0000_1051);
      rd_chk("last addr", 32'h0C, 32'h0001_57FF);
      rd_chk("unmapped", 32'h10, 32'h0000_0000);
      check_bit("hresp", 1'b0, hresp);
      // Interrupt raised, cleared, then masked
      ahb(1'b1, 32'h00, 32'h0000_0007);
      ahb(1'b1, 32'h04, 32'h0000_0001);
      rd_chk("mask", 32'h04, 32'h0000_0001);
      check_bit("irq idle", 1'b0, irq);
      pmwp_nvm_model_i.check(1'b0, 24'h00_1000, g, d);
      repeat (3) @(posedge clock);
      check_bit("irq set", 1'b1, irq);
      rd_chk("status", 32'h00, 32'h0000_0001);
      ahb(1'b1, 32'h00, 32'h0000_0001);
      repeat (3) @(posedge clock);
      check_bit("irq clear", 1'b0, irq);
      ahb(1'b1, 32'h04, 32'h0000_0000);
      pmwp_nvm_model_i.check(1'b0, 24'h00_1000, g, d);
      repeat (3) @(posedge clock);
      check_bit("irq masked", 1'b0, irq);
      // Disturbed live bit forces device reset until reload
      ahb(1'b1, 32'h04, 32'h0000_0004);
      @(posedge clock);
      cfg_upset <= 12'h010;
      @(posedge clock);
      cfg_upset <= 12'h000;
      repeat (4) @(posedge clock);
      check_bit("dev_reset", 1'b1, dev_reset);
      check_bit("irq parity", 1'b1, irq);
      rd_chk("status parity", 32'h00, 32'h0000_0005);
      load(12'hFFF);
      repeat (3) @(posedge clock);
      check_bit("dev_reset off", 1'b0, dev_reset);
      complete_run;
   end
endmodule // test_program_memory_write_protection
`default_nettype wire
